// >>> design/oek_osc_ctrl.sv
// key-protected oscillator enable register with stable flags over AXI4-Lite
//
// Function
// [RL1] control register writes need unlock key 0xCB14 written first
// [RL2] any other register write after unlocking relocks the protection
// [RL3] key register is 16-bit read/write, resets to zero
// [RL4] bit 10 reads 1 once enabled crystal is stable, else 0
// [RL5] bit 9 reads 1 once enabled fast internal oscillator is stable
// [RL6] bit 8 reads 1 once enabled slow internal oscillator is stable
// [RL7] stable bits are not loss monitors; they stay set while enabled
// [RL8] bit 2 enables crystal, resets to 0
// [RL9] bit 1 enables fast internal oscillator, resets to 1
// [RL10] bit 0 enables slow internal oscillator, resets to 1
// [RL11] software sets both fast enables before requesting processor reset
// [RL12] software uses an oscillator only after its stable bit is set
// [RL13] locked control writes ignored; wrong key keeps lock engaged
//
// Implementation choice: the AXI4-Lite slave port.
`default_nettype none
module oek_osc_ctrl (
   // clock and reset
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   // axi4-lite write address
   input  wire logic [oek_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   // axi4-lite write response
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   // axi4-lite read address
   input  wire logic [oek_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   // axi4-lite read data
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   // oscillator pads
   output logic                           crystal_enable,
   output logic                           fast_internal_enable,
   output logic                           slow_internal_enable,
   input  wire logic                      crystal_ready,
   input  wire logic                      fast_internal_ready,
   input  wire logic                      slow_internal_ready,
   // interrupt
   output logic                           irq
);
   import oek_pkg::*;

   // ------------------------------------------------------------
   // write channel capture
   // ------------------------------------------------------------
   logic [ADDR_W-1:0] aw_addr;
   logic              aw_full;
   logic [31:0]       w_data;
   logic [3:0]        w_strb;
   logic              w_full;
   logic              wr_fire;

   assign s_axi_awready = !aw_full && !s_axi_bvalid;
   assign s_axi_wready  = !w_full && !s_axi_bvalid;
   assign wr_fire       = aw_full && w_full && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         aw_addr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_full <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_full <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_full <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_full <= 1'b0;
      end
   end

   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      logic hit;
      hit = 1'b0;
      if (a == OSC_UNLOCK_KEY_ADDR) begin
         hit = 1'b1;
      end else if (a == OSC_ENABLE_STATUS_ADDR) begin
         hit = 1'b1;
      end else if (a == IRQ_STATUS_ADDR) begin
         hit = 1'b1;
      end else if (a == IRQ_ENABLE_ADDR) begin
         hit = 1'b1;
      end else if (a == IRQ_CLEAR_ADDR) begin
         hit = 1'b1;
      end
      return hit;
   endfunction : is_mapped

   // merge byte lanes into a 16-bit register value
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
      logic [15:0] r;
      r = old;
      if (s[0]) begin
         r[7:0] = d[7:0];
      end
      if (s[1]) begin
         r[15:8] = d[15:8];
      end
      return r;
   endfunction : merge16

   logic wr_key;
   logic wr_ctrl;
   logic wr_ien;
   logic wr_iclr;

   always_comb begin
      wr_key  = 1'b0;
      wr_ctrl = 1'b0;
      wr_ien  = 1'b0;
      wr_iclr = 1'b0;
      if (wr_fire) begin
         if (aw_addr == OSC_UNLOCK_KEY_ADDR) begin
            wr_key = 1'b1;
         end else if (aw_addr == OSC_ENABLE_STATUS_ADDR) begin
            wr_ctrl = 1'b1;
         end else if (aw_addr == IRQ_ENABLE_ADDR) begin
            wr_ien = 1'b1;
         end else if (aw_addr == IRQ_CLEAR_ADDR) begin
            wr_iclr = 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // key register and lock
   // ------------------------------------------------------------
   logic [15:0] key_reg;
   logic [15:0] next_key;
   logic        unlocked;

   assign next_key = merge16(key_reg, w_data, w_strb);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         key_reg <= KEY_RESET;                                 // see [RL3]
      end else if (wr_key) begin
         key_reg <= next_key;                                  // see [RL3]
      end
   end

   // any completed write other than the key's consumes or drops the unlock
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         unlocked <= 1'b0;
      end else if (wr_key) begin
         unlocked <= (next_key == UNLOCK_VALUE);               // see [RL1] see [RL13]
      end else if (wr_fire) begin
         unlocked <= 1'b0;                                     // see [RL2]
      end
   end

   // ------------------------------------------------------------
   // enable bits
   // ------------------------------------------------------------
   logic [2:0] enables;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enables <= ENABLE_RESET;                              // see [RL8] see [RL9] see [RL10]
      end else if (wr_ctrl && unlocked && w_strb[0]) begin
         enables <= w_data[2:0];                               // see [RL1] see [RL13]
      end
   end

   assign crystal_enable       = enables[CRYSTAL_EN_BIT];      // see [RL8]
   assign fast_internal_enable = enables[FAST_EN_BIT];         // see [RL9]
   assign slow_internal_enable = enables[SLOW_EN_BIT];         // see [RL10]

   // ------------------------------------------------------------
   // stable flags
   // ------------------------------------------------------------
   logic crystal_stable_flag;
   logic fast_internal_stable_flag;
   logic slow_internal_stable_flag;
   logic [2:0] stable_rise;

   oek_stable_sync u_crystal (
      .aclk    (aclk),
      .aresetn (aresetn),
      .enable  (crystal_enable),
      .ready_pin (crystal_ready),
      .stable  (crystal_stable_flag),                          // see [RL4] see [RL7]
      .rise    (stable_rise[2])
   );
   oek_stable_sync u_fast (
      .aclk    (aclk),
      .aresetn (aresetn),
      .enable  (fast_internal_enable),
      .ready_pin (fast_internal_ready),
      .stable  (fast_internal_stable_flag),                    // see [RL5] see [RL7]
      .rise    (stable_rise[1])
   );
   oek_stable_sync u_slow (
      .aclk    (aclk),
      .aresetn (aresetn),
      .enable  (slow_internal_enable),
      .ready_pin (slow_internal_ready),
      .stable  (slow_internal_stable_flag),                    // see [RL6] see [RL7]
      .rise    (stable_rise[0])
   );

   // ------------------------------------------------------------
   // interrupts: sticky status, enable, write-one-to-clear
   // ------------------------------------------------------------
   logic [2:0] irq_status;
   logic [2:0] irq_enable;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_enable <= 3'h0;
      end else if (wr_ien && w_strb[0]) begin
         irq_enable <= w_data[2:0];
      end
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= 3'h0;
      end else begin
         irq_status <= (irq_status & ~((wr_iclr && w_strb[0]) ? w_data[2:0] : 3'h0)) | stable_rise;
      end
   end

   assign irq = |(irq_status & irq_enable);

   // ------------------------------------------------------------
   // read channel
   // ------------------------------------------------------------
   function automatic logic [31:0] read_mux(input logic [ADDR_W-1:0] a, input logic [15:0] k,
                                            input logic [15:0] c, input logic [2:0] st, input logic [2:0] en);
      logic [31:0] r;
      r = 32'h0000_0000;
      if (a == OSC_UNLOCK_KEY_ADDR) begin
         r = {16'h0000, k};
      end else if (a == OSC_ENABLE_STATUS_ADDR) begin
         r = {16'h0000, c};
      end else if (a == IRQ_STATUS_ADDR) begin
         r = {29'h0, st};
      end else if (a == IRQ_ENABLE_ADDR) begin
         r = {29'h0, en};
      end
      return r;
   endfunction : read_mux

   logic [15:0] ctrl_view;

   always_comb begin
      ctrl_view                 = 16'h0000;
      ctrl_view[2:0]            = enables;
      ctrl_view[CRYSTAL_OK_BIT] = crystal_stable_flag;         // see [RL4]
      ctrl_view[FAST_OK_BIT]    = fast_internal_stable_flag;   // see [RL5]
      ctrl_view[SLOW_OK_BIT]    = slow_internal_stable_flag;   // see [RL6]
   end

   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= read_mux(s_axi_araddr, key_reg, ctrl_view, irq_status, irq_enable);
         s_axi_rresp  <= is_mapped(s_axi_araddr) && s_axi_araddr != IRQ_CLEAR_ADDR ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   locked_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RL13]
      wr_ctrl && !unlocked |=> enables == $past(enables))
      else $error("locked control write changed enables");
   unlock_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RL1]
      wr_ctrl && unlocked && w_strb[0] |=> enables == $past(w_data[2:0]))
      else $error("unlocked control write not taken");
   relock_other_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RL2]
      wr_fire && !wr_key |=> !unlocked)
      else $error("lock not restored after other write");
   wrong_key_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RL13]
      wr_key && next_key != UNLOCK_VALUE |=> !unlocked)
      else $error("wrong key unlocked");
   key_store_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RL3]
      wr_key && w_strb == 4'hF |=> key_reg == $past(w_data[15:0]))
      else $error("key register not stored");
   crystal_ok_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RL4]
      !crystal_enable |=> !ctrl_view[CRYSTAL_OK_BIT])
      else $error("crystal ok while disabled");
   fast_ok_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RL5]
      !fast_internal_enable |=> !ctrl_view[FAST_OK_BIT])
      else $error("fast ok while disabled");
   slow_ok_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RL6] see [RL7]
      slow_internal_stable_flag && slow_internal_enable |=> slow_internal_stable_flag)
      else $error("slow ok dropped while enabled");
   enable_reset_a: assert property (@(posedge aclk) // see [RL8] see [RL9] see [RL10]
      !aresetn |=> enables == ENABLE_RESET)
      else $error("enable reset value wrong");
   event_latch_a: assert property (@(posedge aclk) disable iff (!aresetn)
      stable_rise != 3'h0 |=> (irq_status & $past(stable_rise)) == $past(stable_rise))
      else $error("stability event not latched");

   unlock_cover_c: cover property (@(posedge aclk) disable iff (!aresetn) wr_ctrl && unlocked);
   locked_cover_c: cover property (@(posedge aclk) disable iff (!aresetn) wr_ctrl && !unlocked);
   relock_cover_c: cover property (@(posedge aclk) disable iff (!aresetn) unlocked && wr_fire && !wr_ctrl && !wr_key);
   stable_cover_c: cover property (@(posedge aclk) disable iff (!aresetn) crystal_stable_flag);
endmodule : oek_osc_ctrl
`default_nettype wire

// >>> design/oek_pkg.sv
// constants of the oscillator enable and key lock block
`default_nettype none
package oek_pkg;
   // register byte addresses
   localparam logic [11:0] OSC_UNLOCK_KEY_ADDR    = 12'hA0C;
   localparam logic [11:0] OSC_ENABLE_STATUS_ADDR = 12'hA10;
   localparam logic [11:0] IRQ_STATUS_ADDR        = 12'hA14;
   localparam logic [11:0] IRQ_ENABLE_ADDR        = 12'hA18;
   localparam logic [11:0] IRQ_CLEAR_ADDR         = 12'hA1C;
   localparam int          ADDR_W                 = 12;
   // key and reset values
   localparam logic [15:0] UNLOCK_VALUE      = 16'hCB14;
   localparam logic [15:0] KEY_RESET         = 16'h0000;
   localparam logic [2:0]  ENABLE_RESET      = 3'h3;
   // field positions
   localparam int SLOW_EN_BIT     = 0;
   localparam int FAST_EN_BIT     = 1;
   localparam int CRYSTAL_EN_BIT  = 2;
   localparam int SLOW_OK_BIT     = 8;
   localparam int FAST_OK_BIT     = 9;
   localparam int CRYSTAL_OK_BIT  = 10;
   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // synchroniser depth
   localparam int SYNC_STAGES = 3;
endpackage : oek_pkg
`default_nettype wire

// >>> design/oek_stable_sync.sv
// three-stage synchroniser and sticky stable flag for one oscillator
`default_nettype none
module oek_stable_sync (
   // clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // oscillator side
   input  wire logic enable,
   input  wire logic ready_pin,
   // status
   output logic      stable,
   output logic      rise
);
   import oek_pkg::*;

   logic [SYNC_STAGES-1:0] sync;
   logic                   agreed;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync <= '0;
      end else begin
         sync <= {sync[SYNC_STAGES-2:0], ready_pin};
      end
   end

   // level counts once the second and third stages agree
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         agreed <= 1'b0;
      end else if (sync[1] == sync[2]) begin
         agreed <= sync[2];
      end
   end

   // sticky until disabled: later loss is not reported
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stable <= 1'b0;
      end else if (!enable) begin
         stable <= 1'b0;
      end else if (agreed) begin
         stable <= 1'b1;
      end
   end

   assign rise = enable && agreed && !stable;

   sticky_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RL7]
      stable && enable |=> stable)
      else $error("stable flag dropped while enabled");
   disabled_clear_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RL4] see [RL5] see [RL6]
      !enable |=> !stable)
      else $error("stable flag set while disabled");
endmodule : oek_stable_sync
`default_nettype wire

// >>> testbench/oek_osc_ctrl_tb_top.sv
// self-checking bench for the key-protected oscillator enable block
`default_nettype none
module oek_osc_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import oek_pkg::*;

   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic              aclk;
   logic              aresetn;
   logic [ADDR_W-1:0] s_axi_awaddr;
   logic              s_axi_awvalid, s_axi_awready;
   logic [31:0]       s_axi_wdata;
   logic [3:0]        s_axi_wstrb;
   logic              s_axi_wvalid, s_axi_wready;
   logic [1:0]        s_axi_bresp;
   logic              s_axi_bvalid, s_axi_bready;
   logic [ADDR_W-1:0] s_axi_araddr;
   logic              s_axi_arvalid, s_axi_arready;
   logic [31:0]       s_axi_rdata;
   logic [1:0]        s_axi_rresp;
   logic              s_axi_rvalid, s_axi_rready;
   logic              crystal_enable, fast_internal_enable, slow_internal_enable;
   logic              crystal_ready, fast_internal_ready, slow_internal_ready;
   logic              irq;
   int                fail_count;
   int                compares;
   logic [31:0]       got;
   logic [1:0]        rsp;
   int                n;

   // ----------------------------------------
   // design under test
   // ----------------------------------------
   oek_osc_ctrl oek_osc_ctrl_i (
      .aclk, .aresetn,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .crystal_enable, .fast_internal_enable, .slow_internal_enable,
      .crystal_ready, .fast_internal_ready, .slow_internal_ready,
      .irq
   );

   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic close_out;
      $display("comparisons %0d, mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : close_out

   task automatic hung;
      fail_count++;
      $display("CHECK FAILED bus answer expected within 50 cycles seen none");
      close_out();
   endtask : hung

   // ready is sampled at the negedge, where it already holds its value for the coming edge
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      int k;
      logic haw, hw, hb, done;
      logic [1:0] r;
      k = 0;
      done = 1'b0;
      r = 2'h3;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!done) begin
         @(negedge aclk);
         haw = s_axi_awvalid & s_axi_awready;
         hw = s_axi_wvalid & s_axi_wready;
         hb = s_axi_bvalid & s_axi_bready;
         r = s_axi_bresp;
         @(posedge aclk);
         k++;
         if (haw) s_axi_awvalid <= 1'b0;
         if (hw) s_axi_wvalid <= 1'b0;
         if (hb) begin
            s_axi_bready <= 1'b0;
            done = 1'b1;
         end
         if (k > 50) hung();
      end
      chk("write response", {30'h0, er}, {30'h0, r});
   endtask : wr

   task automatic rd_raw(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      int k;
      logic har, hr, done;
      k = 0;
      done = 1'b0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!done) begin
         @(negedge aclk);
         har = s_axi_arvalid & s_axi_arready;
         hr = s_axi_rvalid & s_axi_rready;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
         k++;
         if (har) s_axi_arvalid <= 1'b0;
         if (hr) begin
            s_axi_rready <= 1'b0;
            done = 1'b1;
         end
         if (k > 50) hung();
      end
   endtask : rd_raw

   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er, input string nm);
      logic [31:0] d;
      logic [1:0] r;
      rd_raw(a, d, r);
      chk(nm, exp, d);
      chk("read response", {30'h0, er}, {30'h0, r});
   endtask : rd

   function automatic logic [31:0] pins();
      return {29'h0, crystal_enable, fast_internal_enable, slow_internal_enable};
   endfunction : pins

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      fail_count = 0;
      compares = 0;
      aresetn = 1'b0;
      s_axi_awaddr = '0;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = '0;
      s_axi_wstrb = 4'hF;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = '0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      {crystal_ready, fast_internal_ready, slow_internal_ready} = 3'h0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      // reset state
      rd(OSC_UNLOCK_KEY_ADDR, 32'h0, RESP_OKAY, "key at reset");
      rd(OSC_ENABLE_STATUS_ADDR, 32'h3, RESP_OKAY, "control at reset");
      chk("enable pins at reset", 32'h3, pins());
      // locked, wrong key, and an intervening write all leave control untouched
      wr(OSC_ENABLE_STATUS_ADDR, 32'h7, RESP_OKAY);
      rd(OSC_ENABLE_STATUS_ADDR, 32'h3, RESP_OKAY, "locked write");
      wr(OSC_UNLOCK_KEY_ADDR, 32'h1234, RESP_OKAY);
      wr(OSC_ENABLE_STATUS_ADDR, 32'h7, RESP_OKAY);
      rd(OSC_ENABLE_STATUS_ADDR, 32'h3, RESP_OKAY, "wrong key");
      wr(OSC_UNLOCK_KEY_ADDR, {16'h0, UNLOCK_VALUE}, RESP_OKAY);
      wr(IRQ_ENABLE_ADDR, 32'h0, RESP_OKAY);
      wr(OSC_ENABLE_STATUS_ADDR, 32'h7, RESP_OKAY);
      rd(OSC_ENABLE_STATUS_ADDR, 32'h3, RESP_OKAY, "relocked");
      // proper unlock
      wr(OSC_UNLOCK_KEY_ADDR, {16'h0, UNLOCK_VALUE}, RESP_OKAY);
      rd(OSC_UNLOCK_KEY_ADDR, {16'h0, UNLOCK_VALUE}, RESP_OKAY, "key readback");
      wr(OSC_ENABLE_STATUS_ADDR, 32'h7, RESP_OKAY);
      rd(OSC_ENABLE_STATUS_ADDR, 32'h7, RESP_OKAY, "unlocked write");
      chk("enable pins", 32'h7, pins());
      // oscillators settle
      @(posedge aclk);
      {crystal_ready, fast_internal_ready, slow_internal_ready} <= 3'h7;
      n = 0;
      do begin
         rd_raw(OSC_ENABLE_STATUS_ADDR, got, rsp);
         n++;
      end while (got !== 32'h707 && n < 20);
      chk("stable flags", 32'h707, got);
      @(posedge aclk);
      {crystal_ready, fast_internal_ready, slow_internal_ready} <= 3'h0;
      repeat (8) @(posedge aclk);
      rd(OSC_ENABLE_STATUS_ADDR, 32'h707, RESP_OKAY, "flags after loss");
      // interrupt: raise, mask, clear
      rd(IRQ_STATUS_ADDR, 32'h7, RESP_OKAY, "irq status");
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(IRQ_ENABLE_ADDR, 32'h2, RESP_OKAY);
      chk("irq enabled", 32'h1, {31'h0, irq});
      wr(IRQ_CLEAR_ADDR, 32'h2, RESP_OKAY);
      chk("irq cleared", 32'h0, {31'h0, irq});
      rd(IRQ_STATUS_ADDR, 32'h5, RESP_OKAY, "irq status after clear");
      wr(IRQ_CLEAR_ADDR, 32'h5, RESP_OKAY);
      rd(IRQ_STATUS_ADDR, 32'h0, RESP_OKAY, "irq status empty");
      // disabling clears the flag
      wr(OSC_UNLOCK_KEY_ADDR, {16'h0, UNLOCK_VALUE}, RESP_OKAY);
      wr(OSC_ENABLE_STATUS_ADDR, 32'h3, RESP_OKAY);
      rd(OSC_ENABLE_STATUS_ADDR, 32'h303, RESP_OKAY, "crystal off");
      wr(OSC_UNLOCK_KEY_ADDR, {16'h0, UNLOCK_VALUE}, RESP_OKAY);
      wr(OSC_ENABLE_STATUS_ADDR, 32'h0, RESP_OKAY);
      chk("enable pins off", 32'h0, pins());
      @(posedge aclk);
      {crystal_ready, fast_internal_ready, slow_internal_ready} <= 3'h7;
      repeat (8) @(posedge aclk);
      rd(OSC_ENABLE_STATUS_ADDR, 32'h0, RESP_OKAY, "disabled flags");
      // processor reset request, made with both fast enables set
      wr(OSC_UNLOCK_KEY_ADDR, {16'h0, UNLOCK_VALUE}, RESP_OKAY);
      wr(OSC_ENABLE_STATUS_ADDR, 32'h6, RESP_OKAY);
      chk("fast enables before reset", 32'h6, pins());
      @(posedge aclk);
      aresetn <= 1'b0;
      {crystal_ready, fast_internal_ready, slow_internal_ready} <= 3'h0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rd(OSC_UNLOCK_KEY_ADDR, 32'h0, RESP_OKAY, "key after reset");
      rd(OSC_ENABLE_STATUS_ADDR, 32'h3, RESP_OKAY, "control after reset");
      rd(IRQ_STATUS_ADDR, 32'h0, RESP_OKAY, "irq status after reset");
      // unmapped and write-only places
      rd(12'h000, 32'h0, RESP_SLVERR, "unmapped read");
      wr(12'h000, 32'h1, RESP_SLVERR);
      rd(IRQ_CLEAR_ADDR, 32'h0, RESP_SLVERR, "clear register read");
      close_out();
   end
endmodule : oek_osc_ctrl_tb_top
`default_nettype wire
